/* rtl/lpi_params.svh */
// Purpose: constants of the level/pin/source priority interrupt controller
// Assumes: included by the filter, event register and core design files of the block
// Notes:   definitions only
`ifndef LPI_PARAMS_SVH
`define LPI_PARAMS_SVH

// event codes
`define LPI_CODE_NMI      12'h1c0
`define LPI_CODE_DEBUG    12'h5e0
`define LPI_CODE_ENC_BASE 12'h200
`define LPI_CODE_EXT_BASE 12'h600
`define LPI_CODE_PORT     12'h700
`define LPI_CODE_DMA      12'h800
`define LPI_CODE_IRDA     12'h880
`define LPI_CODE_FIFO     12'h900
`define LPI_CODE_CONV     12'h980
`define LPI_CODE_TIMER    12'h400
`define LPI_CODE_RTC      12'h480
`define LPI_CODE_SCI      12'h4e0
`define LPI_CODE_WDT      12'h560
`define LPI_CODE_REF      12'h580
`define LPI_CODE_STEP_SH  5
`define LPI_EVT_RESET     12'h000

// levels and pin values
`define LPI_LEVEL_NMI     5'd16
`define LPI_LEVEL_DEBUG   5'd15
`define LPI_LEVEL_TOP     4'hf
`define LPI_ENC_IDLE      4'hf

// priority field positions (nibble index within a register)
`define LPI_NIB_15_12     2'd3
`define LPI_NIB_11_8      2'd2
`define LPI_NIB_7_4       2'd1
`define LPI_NIB_3_0       2'd0
`define LPI_PRIO_RESET    16'h0000

`endif

/* rtl/lpi_pkg.sv */
// Purpose: types of the level/pin/source priority interrupt controller
// Assumes: nothing
// Notes:   constants live in lpi_params.svh
package lpi_pkg;
  typedef logic [4:0]  lpi_level_t;
  typedef logic [11:0] lpi_code_t;
  typedef logic [15:0] lpi_prio_t;
  typedef enum logic [1:0] {
    LPI_MODE_EXT_PIN,
    LPI_MODE_ENC_ONLY,
    LPI_MODE_ENC_AUX
  } lpi_pin_mode_t;
endpackage

/* rtl/lpi_level_filter.sv */
// Purpose: two-sample noise filter for one 4-bit encoded level pin group
// Assumes: sample_en picks the sampling rate (every clock, or 32-kHz ticks)
// Notes:   output idles at the no-request code
`timescale 1ns/10ps
`include "lpi_params.svh"
module lpi_level_filter (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // sampling
  input  wire logic       sample_en,
  input  wire logic [3:0] pins,
  // filtered value
  output logic      [3:0] level_pins
);
  logic [3:0] last;
  logic [3:0] next_last;
  logic [3:0] next_level_pins;

  always_comb begin
    next_last       = last;
    next_level_pins = level_pins;
    if (sample_en) begin
      next_last = pins;
      if (pins == last) begin
        next_level_pins = pins;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last       <= `LPI_ENC_IDLE;
      level_pins <= `LPI_ENC_IDLE;
    end else begin
      last       <= next_last;
      level_pins <= next_level_pins;
    end
  end
endmodule // lpi_level_filter

/* rtl/lpi_event_regs.sv */
// Purpose: event code register pair, loaded on acceptance
// Assumes: load is a one-cycle pulse
// Notes:   holds until the next acceptance
`timescale 1ns/10ps
`include "lpi_params.svh"
module lpi_event_regs (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // load
  input  wire logic                load,
  input  wire lpi_pkg::lpi_code_t  code_first,
  input  wire lpi_pkg::lpi_code_t  code_second,
  // registers
  output lpi_pkg::lpi_code_t       event_code_reg,
  output lpi_pkg::lpi_code_t       event_code_reg_second
);
  lpi_pkg::lpi_code_t next_first;
  lpi_pkg::lpi_code_t next_second;

  always_comb begin
    next_first  = event_code_reg;
    next_second = event_code_reg_second;
    if (load) begin
      next_first  = code_first;
      next_second = code_second;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      event_code_reg        <= `LPI_EVT_RESET;
      event_code_reg_second <= `LPI_EVT_RESET;
    end else begin
      event_code_reg        <= next_first;
      event_code_reg_second <= next_second;
    end
  end
endmodule // lpi_event_regs

/* rtl/lpi_intc.sv */
// Purpose: level/pin/source priority interrupt controller core
// Assumes: all inputs synchronous to clk; rtc_tick is a one-cycle 32-kHz tick
// Notes:   standby keeps clk but filters encoded pins only on rtc_tick
`timescale 1ns/10ps
`include "lpi_params.svh"
module lpi_intc #(
  parameter int NSRC = 38
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rstn,
  // control register 1 bits
  input  wire logic                level_select_bit,
  input  wire logic                aux_enable_bit,
  // priority register writes
  input  wire logic [4:0]          prio_wr,
  input  wire lpi_pkg::lpi_prio_t  prio_wdata,
  // priority register readback
  output lpi_pkg::lpi_prio_t       priority_reg_a,
  output lpi_pkg::lpi_prio_t       priority_reg_b,
  output lpi_pkg::lpi_prio_t       priority_reg_c,
  output lpi_pkg::lpi_prio_t       priority_reg_d,
  output lpi_pkg::lpi_prio_t       priority_reg_e,
  // pins
  input  wire logic [3:0]          enc_level_pins,
  input  wire logic [3:0]          aux_enc_level_pins,
  input  wire logic [5:0]          ext_req,
  input  wire logic [15:0]         port_request_pins,
  input  wire logic                nmi_req,
  // on-chip requests
  input  wire logic                debug_req,
  input  wire logic [3:0]          dma_end,
  input  wire logic [3:0]          irda_req,
  input  wire logic [3:0]          fifo_serial_req,
  input  wire logic                converter_done,
  input  wire logic [2:0]          timer_underflow,
  input  wire logic                timer2_capture,
  input  wire logic [2:0]          rtc_req,
  input  wire logic [3:0]          sci_req,
  input  wire logic                wdt_req,
  input  wire logic [1:0]          refresh_req,
  // power state
  input  wire logic                standby,
  input  wire logic                rtc_osc_used,
  input  wire logic                rtc_tick,
  output logic                     wake_req,
  // processor side
  input  wire logic [3:0]          mask_level_field,
  output logic                     cpu_req,
  output lpi_pkg::lpi_level_t      cpu_level,
  input  wire logic                cpu_ack,
  output logic                     accepted,
  output lpi_pkg::lpi_code_t       event_code_reg,
  output lpi_pkg::lpi_code_t       event_code_reg_second
);
  localparam int IDX_NMI = 0;
  localparam int IDX_DBG = 1;
  localparam int IDX_ENC = 2;
  localparam int IDX_EXT = 3;
  localparam int IDX_PRT = 9;
  localparam int IDX_DMA = 11;
  localparam int IDX_IRD = 15;
  localparam int IDX_FIF = 19;
  localparam int IDX_CNV = 23;
  localparam int IDX_TMR = 24;
  localparam int IDX_RTC = 28;
  localparam int IDX_SCI = 31;
  localparam int IDX_WDT = 35;
  localparam int IDX_REF = 36;

  function automatic lpi_pkg::lpi_code_t sub_code(lpi_pkg::lpi_code_t base, logic [2:0] k);
    return base + lpi_pkg::lpi_code_t'({k, 5'h00});
  endfunction

  function automatic lpi_pkg::lpi_level_t nib(lpi_pkg::lpi_prio_t r, logic [1:0] n);
    return {1'b0, r[n*4 +: 4]};
  endfunction

  // level-dependent code shared by the level-coded sources
  function automatic lpi_pkg::lpi_code_t level_code(lpi_pkg::lpi_level_t lvl);
    logic [3:0] n;
    n = `LPI_LEVEL_TOP - lvl[3:0];
    return `LPI_CODE_ENC_BASE + lpi_pkg::lpi_code_t'({n, 5'h00});
  endfunction

  // reset release through two flops
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // priority registers
  lpi_pkg::lpi_prio_t next_a, next_b, next_c, next_d, next_e;
  always_comb begin
    next_a = prio_wr[0] ? prio_wdata : priority_reg_a;
    next_b = prio_wr[1] ? prio_wdata : priority_reg_b;
    next_c = prio_wr[2] ? prio_wdata : priority_reg_c;
    next_d = prio_wr[3] ? prio_wdata : priority_reg_d;
    next_e = prio_wr[4] ? prio_wdata : priority_reg_e;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      priority_reg_a <= `LPI_PRIO_RESET;
      priority_reg_b <= `LPI_PRIO_RESET;
      priority_reg_c <= `LPI_PRIO_RESET;
      priority_reg_d <= `LPI_PRIO_RESET;
      priority_reg_e <= `LPI_PRIO_RESET;
    end else begin
      priority_reg_a <= next_a;
      priority_reg_b <= next_b;
      priority_reg_c <= next_c;
      priority_reg_d <= next_d;
      priority_reg_e <= next_e;
    end
  end

  // pin mode
  lpi_pkg::lpi_pin_mode_t pin_mode;
  always_comb begin
    if (!level_select_bit) begin
      pin_mode = lpi_pkg::LPI_MODE_EXT_PIN;
    end else if (aux_enable_bit) begin
      pin_mode = lpi_pkg::LPI_MODE_ENC_AUX;
    end else begin
      pin_mode = lpi_pkg::LPI_MODE_ENC_ONLY;
    end
  end

  // encoded pin filters; clk is kept, so standby slows sampling instead
  logic       sample_en;
  logic [3:0] enc_filt;
  logic [3:0] aux_filt;
  assign sample_en = !standby || (rtc_osc_used && rtc_tick);

  lpi_level_filter u_enc_filter (
    .clk        (clk),
    .rst_n      (rst_n),
    .sample_en  (sample_en),
    .pins       (enc_level_pins),
    .level_pins (enc_filt)
  );

  lpi_level_filter u_aux_filter (
    .clk        (clk),
    .rst_n      (rst_n),
    .sample_en  (sample_en),
    .pins       (aux_enc_level_pins),
    .level_pins (aux_filt)
  );

  // lower pin value is the higher level
  logic [3:0]          enc_val;
  lpi_pkg::lpi_level_t enc_level;
  always_comb begin
    enc_val = enc_filt;
    if (pin_mode == lpi_pkg::LPI_MODE_ENC_AUX && aux_filt < enc_filt) begin
      enc_val = aux_filt;
    end
    enc_level = {1'b0, `LPI_LEVEL_TOP - enc_val};
  end

  // source table in default order
  logic                req  [NSRC];
  lpi_pkg::lpi_level_t lvl  [NSRC];
  lpi_pkg::lpi_code_t  code [NSRC];
  logic                same [NSRC];
  always_comb begin
    for (int i = 0; i < NSRC; i++) begin
      req[i]  = 1'b0;
      lvl[i]  = 5'd0;
      code[i] = `LPI_EVT_RESET;
      same[i] = 1'b0;
    end
    req[IDX_NMI]  = nmi_req;
    lvl[IDX_NMI]  = `LPI_LEVEL_NMI;
    code[IDX_NMI] = `LPI_CODE_NMI;
    same[IDX_NMI] = 1'b1;
    req[IDX_DBG]  = debug_req;
    lvl[IDX_DBG]  = `LPI_LEVEL_DEBUG;
    code[IDX_DBG] = `LPI_CODE_DEBUG;
    same[IDX_DBG] = 1'b1;
    req[IDX_ENC]  = (pin_mode != lpi_pkg::LPI_MODE_EXT_PIN) && (enc_val != `LPI_ENC_IDLE);
    lvl[IDX_ENC]  = enc_level;
    code[IDX_ENC] = level_code(enc_level);
    same[IDX_ENC] = 1'b1;
    for (int k = 0; k < 6; k++) begin
      // pins 0-3 double as encoded pins in encoded mode
      req[IDX_EXT+k]  = ext_req[k] && (pin_mode == lpi_pkg::LPI_MODE_EXT_PIN || k > 3);
      lvl[IDX_EXT+k]  = (k < 4) ? nib(priority_reg_c, 2'(k)) : nib(priority_reg_d, 2'(k - 4));
      code[IDX_EXT+k] = sub_code(`LPI_CODE_EXT_BASE, 3'(k));
    end
    req[IDX_PRT]    = |port_request_pins[7:0];
    lvl[IDX_PRT]    = nib(priority_reg_d, `LPI_NIB_15_12);
    code[IDX_PRT]   = `LPI_CODE_PORT;
    req[IDX_PRT+1]  = |port_request_pins[15:8];
    lvl[IDX_PRT+1]  = nib(priority_reg_d, `LPI_NIB_11_8);
    code[IDX_PRT+1] = sub_code(`LPI_CODE_PORT, 3'd1);
    for (int k = 0; k < 4; k++) begin
      req[IDX_DMA+k]  = dma_end[k];
      lvl[IDX_DMA+k]  = nib(priority_reg_e, `LPI_NIB_15_12);
      code[IDX_DMA+k] = sub_code(`LPI_CODE_DMA, 3'(k));
      req[IDX_IRD+k]  = irda_req[k];
      lvl[IDX_IRD+k]  = nib(priority_reg_e, `LPI_NIB_11_8);
      code[IDX_IRD+k] = sub_code(`LPI_CODE_IRDA, 3'(k));
      req[IDX_FIF+k]  = fifo_serial_req[k];
      lvl[IDX_FIF+k]  = nib(priority_reg_e, `LPI_NIB_7_4);
      code[IDX_FIF+k] = sub_code(`LPI_CODE_FIFO, 3'(k));
      req[IDX_SCI+k]  = sci_req[k];
      lvl[IDX_SCI+k]  = nib(priority_reg_b, `LPI_NIB_3_0);
      code[IDX_SCI+k] = sub_code(`LPI_CODE_SCI, 3'(k));
      same[IDX_SCI+k] = 1'b1;
    end
    req[IDX_CNV]  = converter_done;
    lvl[IDX_CNV]  = nib(priority_reg_e, `LPI_NIB_3_0);
    code[IDX_CNV] = `LPI_CODE_CONV;
    for (int k = 0; k < 4; k++) begin
      req[IDX_TMR+k]  = (k < 3) ? timer_underflow[k] : timer2_capture;
      lvl[IDX_TMR+k]  = nib(priority_reg_a, (k < 3) ? 2'(3 - k) : `LPI_NIB_7_4);
      code[IDX_TMR+k] = sub_code(`LPI_CODE_TIMER, 3'(k));
      same[IDX_TMR+k] = 1'b1;
    end
    for (int k = 0; k < 3; k++) begin
      req[IDX_RTC+k]  = rtc_req[k];
      lvl[IDX_RTC+k]  = nib(priority_reg_a, `LPI_NIB_3_0);
      code[IDX_RTC+k] = sub_code(`LPI_CODE_RTC, 3'(k));
      same[IDX_RTC+k] = 1'b1;
    end
    req[IDX_WDT]  = wdt_req;
    lvl[IDX_WDT]  = nib(priority_reg_b, `LPI_NIB_15_12);
    code[IDX_WDT] = `LPI_CODE_WDT;
    same[IDX_WDT] = 1'b1;
    for (int k = 0; k < 2; k++) begin
      req[IDX_REF+k]  = refresh_req[k];
      lvl[IDX_REF+k]  = nib(priority_reg_b, `LPI_NIB_11_8);
      code[IDX_REF+k] = sub_code(`LPI_CODE_REF, 3'(k));
      same[IDX_REF+k] = 1'b1;
    end
  end

  // arbitration: strict compare keeps the earliest source on a tie
  lpi_pkg::lpi_level_t best_lvl;
  lpi_pkg::lpi_code_t  best_first;
  lpi_pkg::lpi_code_t  best_second;
  always_comb begin
    best_lvl    = 5'd0;
    best_first  = `LPI_EVT_RESET;
    best_second = `LPI_EVT_RESET;
    for (int i = 0; i < NSRC; i++) begin
      if (req[i] && lvl[i] > best_lvl) begin
        best_lvl    = lvl[i];
        best_second = code[i];
        best_first  = same[i] ? code[i] : level_code(lvl[i]);
      end
    end
  end

  // wake terms; port pins above 1 and other modules cannot wake
  lpi_pkg::lpi_level_t mask_ext;
  logic                wake_hit;
  always_comb begin
    mask_ext = {1'b0, mask_level_field};
    wake_hit = req[IDX_ENC] && lvl[IDX_ENC] > mask_ext;
    if (|port_request_pins[1:0] && lvl[IDX_PRT] > mask_ext) begin
      wake_hit = 1'b1;
    end
    for (int i = IDX_TMR; i < IDX_SCI; i++) begin
      if (req[i] && lvl[i] > mask_ext) begin
        wake_hit = 1'b1;
      end
    end
  end

  // request to processor; the mask field is only read, never written
  logic                next_cpu_req;
  lpi_pkg::lpi_level_t next_cpu_level;
  lpi_pkg::lpi_code_t  cand_first;
  lpi_pkg::lpi_code_t  cand_second;
  lpi_pkg::lpi_code_t  next_cand_first;
  lpi_pkg::lpi_code_t  next_cand_second;
  logic                next_wake_req;
  logic                next_accepted;
  always_comb begin
    next_cpu_req     = best_lvl > mask_ext;
    next_cpu_level   = best_lvl;
    next_cand_first  = best_first;
    next_cand_second = best_second;
    next_wake_req    = standby && rtc_osc_used && wake_hit;
    next_accepted    = cpu_ack && cpu_req;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_req     <= 1'b0;
      cpu_level   <= 5'd0;
      cand_first  <= `LPI_EVT_RESET;
      cand_second <= `LPI_EVT_RESET;
      wake_req    <= 1'b0;
      accepted    <= 1'b0;
    end else begin
      cpu_req     <= next_cpu_req;
      cpu_level   <= next_cpu_level;
      cand_first  <= next_cand_first;
      cand_second <= next_cand_second;
      wake_req    <= next_wake_req;
      accepted    <= next_accepted;
    end
  end

  // ack takes the codes shown with the request in that same cycle
  lpi_event_regs u_event_regs (
    .clk                   (clk),
    .rst_n                 (rst_n),
    .load                  (next_accepted),
    .code_first            (cand_first),
    .code_second           (cand_second),
    .event_code_reg        (event_code_reg),
    .event_code_reg_second (event_code_reg_second)
  );
endmodule // lpi_intc

/* verification/lpi_intc_asserts.sv */
// Purpose: port-level assertions for the priority interrupt controller
// Assumes: bound to lpi_intc; one clock domain
// Notes:   acceptance shows one cycle after the ack edge
`timescale 1ns/10ps
module lpi_intc_asserts (
  // clock and reset
  input wire logic                clk,
  input wire logic                rstn,
  // watched inputs
  input wire logic                nmi_req,
  input wire logic                standby,
  input wire logic                rtc_osc_used,
  input wire logic [3:0]          mask_level_field,
  input wire logic                cpu_ack,
  // watched outputs
  input wire logic                cpu_req,
  input wire lpi_pkg::lpi_level_t cpu_level,
  input wire logic                accepted,
  input wire logic                wake_req,
  input wire lpi_pkg::lpi_code_t  event_code_reg,
  input wire lpi_pkg::lpi_code_t  event_code_reg_second
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_take;
    cpu_ack && cpu_req;
  endsequence
  sequence s_nmi_taken;
    accepted && $past(cpu_level) == 5'd16;
  endsequence

  AST_ACCEPT: assert property (s_take |=> accepted) else $error("ack not followed by accept");
  AST_ACCEPT_CAUSE: assert property (accepted |-> $past(cpu_ack && cpu_req)) else $error("accept without ack");
  AST_FORWARD: assert property (cpu_req |-> cpu_level > {1'b0, $past(mask_level_field)})
    else $error("request forwarded at or below mask");
  AST_NMI_LEVEL: assert property (nmi_req |=> cpu_req && cpu_level == 5'd16) else $error("nmi level wrong");
  AST_NMI_CODE: assert property (s_nmi_taken |-> event_code_reg == 12'h1c0 && event_code_reg_second == 12'h1c0)
    else $error("nmi code wrong");
  AST_CODE_HOLD: assert property (!accepted |-> $stable(event_code_reg) && $stable(event_code_reg_second))
    else $error("event code changed without accept");
  AST_CODE_STEP: assert property (accepted |-> event_code_reg[4:0] == 5'h00 && event_code_reg_second[4:0] == 5'h00)
    else $error("event code off step");
  AST_WAKE_COND: assert property (wake_req |-> $past(standby) && $past(rtc_osc_used))
    else $error("wake outside standby with oscillator");
endmodule // lpi_intc_asserts

/* verification/lpi_cpu_model.sv */
// Purpose: processor-side partner, acks a pending request
// Assumes: en held by the bench while an acceptance is wanted
// Notes:   one ack per enable, so a level source is not taken twice
`timescale 1ns/10ps
module lpi_cpu_model (
  // clock and reset
  input wire logic       clk,
  input wire logic       rstn,
  // bench control
  input wire logic       en,
  input wire logic [3:0] delay,
  // processor side
  input wire logic       cpu_req,
  output logic           cpu_ack
);
  logic [3:0] wait_cnt;
  logic       armed;

  // mask field is never written here: acceptance leaves it alone
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cpu_ack  <= 1'b0;
      wait_cnt <= 4'h0;
      armed    <= 1'b1;
    end else begin
      cpu_ack <= 1'b0;
      if (!en) begin
        armed    <= 1'b1;
        wait_cnt <= 4'h0;
      end else if (armed && cpu_req) begin
        if (wait_cnt == delay) begin
          cpu_ack <= 1'b1;
          armed   <= 1'b0;
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end
    end
  end
endmodule // lpi_cpu_model

/* verification/level_pin_and_source_priority_intc_test.sv */
// Purpose: self-checking bench for lpi_intc
// Assumes: inputs driven on the falling edge
// Notes:   SCI and refresh requests held idle
`timescale 1ns/10ps
module level_pin_and_source_priority_intc_test;
  logic        clk = 1'b0;
  logic        rstn, lsel, aux_en, nmi, dbg, conv, stby, osc, rtick, cpu_en, cpu_ack, cpu_req, accepted, wake;
  logic [4:0]  prio_wr, cpu_level;
  logic [15:0] wdata, port, pa, pb, pc, pd, pe;
  logic [3:0]  enc, aux, dma, irda, fifo, mask, cpu_delay;
  logic [5:0]  ext;
  logic        tcap, wdt;
  logic [2:0]  tmr, rtc;
  logic [11:0] ev1, ev2;
  int          n_fail = 0;
  int          checked = 0;

  always #12.5 clk = ~clk;

  lpi_intc DUT (.clk(clk), .rstn(rstn), .level_select_bit(lsel), .aux_enable_bit(aux_en), .prio_wr(prio_wr),
    .prio_wdata(wdata), .priority_reg_a(pa), .priority_reg_b(pb), .priority_reg_c(pc), .priority_reg_d(pd),
    .priority_reg_e(pe), .enc_level_pins(enc), .aux_enc_level_pins(aux), .ext_req(ext), .port_request_pins(port),
    .nmi_req(nmi), .debug_req(dbg), .dma_end(dma), .irda_req(irda), .fifo_serial_req(fifo), .converter_done(conv),
    .timer_underflow(tmr), .timer2_capture(tcap), .rtc_req(rtc), .sci_req(4'h0), .wdt_req(wdt),
    .refresh_req(2'h0), .standby(stby), .rtc_osc_used(osc), .rtc_tick(rtick), .wake_req(wake),
    .mask_level_field(mask), .cpu_req(cpu_req), .cpu_level(cpu_level), .cpu_ack(cpu_ack), .accepted(accepted),
    .event_code_reg(ev1), .event_code_reg_second(ev2));

  lpi_cpu_model u_cpu (.clk(clk), .rstn(rstn), .en(cpu_en), .delay(cpu_delay), .cpu_req(cpu_req), .cpu_ack(cpu_ack));

  task automatic complete_run;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr(input int r, input logic [15:0] d);
    prio_wr = 5'(5'h01 << r);
    wdata = d;
    tick(1);
    prio_wr = 5'h00;
  endtask

  // bounded wait for the partner's acceptance, then compare both codes
  task automatic acc(input logic [11:0] e1, input logic [11:0] e2);
    int i;
    cpu_en = 1'b1;
    for (i = 0; i < 30; i++) begin
      tick(1);
      if (accepted === 1'b1) break;
    end
    cpu_en = 1'b0;
    if (i == 30) begin
      n_fail++;
      $display("MISMATCH t=%0t no acceptance", $time);
      complete_run();
    end else begin
      chk({4'h0, ev1}, {4'h0, e1});
      chk({4'h0, ev2}, {4'h0, e2});
    end
  endtask

  initial begin
    {rstn, lsel, aux_en, nmi, dbg, conv, stby, osc, rtick, cpu_en, prio_wr, wdata, port} = '0;
    {dma, irda, fifo, mask, cpu_delay, ext, tmr, rtc, tcap, wdt} = '0;
    enc = 4'hf;
    aux = 4'hf;
    tick(12);
    rstn = 1'b1;
    tick(3);
    chk(pa | pb | pc | pd | pe, 16'h0000);
    dma = 4'hf;
    tick(3);
    chk(cpu_req, 1'b0);
    wr(4, 16'h5000);
    chk(pe, 16'h5000);
    mask = 4'h2;
    tick(2);
    chk(cpu_level, 5'd5);
    for (int i = 0; i < 4; i++) begin
      dma = 4'(4'hf << i);
      tick(2);
      acc(12'h340, 12'h800 + 12'(i * 32));
    end
    mask = 4'h5;
    tick(2);
    chk(cpu_req, 1'b0);
    mask = 4'h4;
    tick(2);
    chk(cpu_req, 1'b1);
    dma = 4'h0;
    mask = 4'h0;
    lsel = 1'b1;
    for (int n = 0; n < 16; n++) begin
      enc = 4'(n);
      tick(4);
      chk(cpu_level, 5'(15 - n));
    end
    chk(cpu_req, 1'b0);
    enc = 4'h5;
    tick(1);
    enc = 4'hf;
    tick(4);
    chk(cpu_level, 5'd0);
    // outside logic only ever raises its level before acceptance
    enc = 4'h5;
    aux = 4'h2;
    tick(4);
    chk(cpu_level, 5'd10);
    aux_en = 1'b1;
    tick(4);
    chk(cpu_level, 5'd13);
    cpu_delay = 4'h3;
    acc(12'h240, 12'h240);
    aux_en = 1'b0;
    tick(4);
    chk(cpu_level, 5'd10);
    nmi = 1'b1;
    tick(2);
    acc(12'h1c0, 12'h1c0);
    nmi = 1'b0;
    dbg = 1'b1;
    tick(2);
    chk(cpu_level, 5'd15);
    acc(12'h5e0, 12'h5e0);
    {dbg, lsel, cpu_delay} = '0;
    enc = 4'hf;
    wr(3, 16'h7007);
    ext = 6'h10;
    port = 16'h0001;
    tick(2);
    acc(12'h300, 12'h680);
    ext = 6'h00;
    tick(2);
    acc(12'h300, 12'h700);
    wr(3, 16'h0600);
    port = 16'h0101;
    tick(2);
    acc(12'h320, 12'h720);
    wr(2, 16'h0009);
    ext = 6'h01;
    tick(2);
    acc(12'h2c0, 12'h600);
    {ext, port} = '0;
    wr(4, 16'h0333);
    {irda, fifo, conv} = {4'hf, 4'hf, 1'b1};
    tick(2);
    acc(12'h380, 12'h880);
    irda = 4'h0;
    tick(2);
    acc(12'h380, 12'h900);
    fifo = 4'h0;
    tick(2);
    acc(12'h380, 12'h980);
    conv = 1'b0;
    wr(0, 16'h3200);
    tmr = 3'b101;
    tick(2);
    acc(12'h400, 12'h400);
    wr(0, 16'h3240);
    tick(2);
    acc(12'h440, 12'h440);
    {tmr, tcap} = {3'b001, 1'b1};
    tick(2);
    acc(12'h460, 12'h460);
    {tmr, tcap} = {3'b101, 1'b0};
    {mask, stby, osc} = {4'h3, 1'b1, 1'b1};
    tick(2);
    chk(wake, 1'b1);
    osc = 1'b0;
    tick(2);
    chk(wake, 1'b0);
    tmr = 3'b000;
    wr(3, 16'h5000);
    {port, osc} = {16'h0001, 1'b1};
    tick(2);
    chk(wake, 1'b1);
    port = 16'h0000;
    tick(2);
    chk(wake, 1'b0);
    wr(0, 16'h3244);
    rtc = 3'h6;
    tick(2);
    chk(wake, 1'b1);
    acc(12'h4a0, 12'h4a0);
    rtc = 3'h0;
    wr(1, 16'h4000);
    wdt = 1'b1;
    tick(2);
    chk(pb, 16'h4000);
    chk(wake, 1'b0);
    acc(12'h560, 12'h560);
    wdt = 1'b0;
    lsel = 1'b1;
    enc = 4'h0;
    tick(4);
    chk(wake, 1'b0);
    // the filter advances only on the slow tick while in standby
    repeat (2) begin
      rtick = 1'b1;
      tick(1);
      rtick = 1'b0;
      tick(3);
    end
    chk(wake, 1'b1);
    stby = 1'b0;
    complete_run();
  end
endmodule // level_pin_and_source_priority_intc_test

bind lpi_intc lpi_intc_asserts u_chk (.clk(clk), .rstn(rstn), .nmi_req(nmi_req), .standby(standby),
  .rtc_osc_used(rtc_osc_used), .mask_level_field(mask_level_field), .cpu_ack(cpu_ack), .cpu_req(cpu_req),
  .cpu_level(cpu_level), .accepted(accepted), .wake_req(wake_req), .event_code_reg(event_code_reg),
  .event_code_reg_second(event_code_reg_second));
